/* File: msgst_pkg.sv */
// How it works
// - handler status flags clear on one, zero ignored
// - reset or clear command zeroes, busy bit set
// - hold number of last updated buffer
// - hold number of last sent buffer
// - updated and sent buffer numbers zeroed on init events
// - faulty buffer number caught, frozen while detected
// - faulty detected, then multiple faulty flag
// - five parity flags, one per RAM
// - parity flag rise pulses error interrupt flag
// - per channel last dynamic slot, segment end
// - slot, FIFO, constraint registers zeroed on init
// - fill level counts unread buffers, max 128
// - overrun overwrites oldest, flag, cleared on read
// - critical flag tracks level against setting
// - not empty set on store, cleared when drained
// - header write blocked outside config, flagged
// - transient buffer access failure flags per channel
// - find sequence unfinished flags per channel
// - status not updated flags per channel
// - constraint flag rise pulses handler interrupt flag
// - constraint flags clear on one, zero on init
// - reserved bits read zero
// - setting above 128 never sets critical
`default_nettype none
package msgst_pkg;

    // ----------------------------------------
    // register indices; byte address is four times
    // ----------------------------------------
    localparam logic [31:0] MSGST_HSTAT_IDX = 32'hffbff310;
    localparam logic [31:0] MSGST_LDTS_IDX = 32'hffbff314;
    localparam logic [31:0] MSGST_FSR_IDX = 32'hffbff31a;
    localparam logic [31:0] MSGST_HDF_IDX = 32'hffbff31e;

    // ----------------------------------------
    // widths
    // ----------------------------------------
    localparam int MSGST_BUF_W = 7;
    localparam int MSGST_SLOT_W = 11;
    localparam int MSGST_FILL_W = 8;
    localparam int MSGST_PAR_N = 5;
    localparam int MSGST_HDF_W = 9;

    // ----------------------------------------
    // handler status fields
    // ----------------------------------------
    localparam int MSGST_UPD_LSB = 24;
    localparam int MSGST_SENT_LSB = 16;
    localparam int MSGST_FAULTY_LSB = 8;
    localparam int MSGST_BUSY_BIT = 7;
    localparam int MSGST_MULT_BIT = 6;
    localparam int MSGST_DET_BIT = 5;
    localparam int MSGST_PAR_LSB = 0;

    // ----------------------------------------
    // slot, fifo and constraint fields
    // ----------------------------------------
    localparam int MSGST_LDT_A_LSB = 0;
    localparam int MSGST_LDT_B_LSB = 16;
    localparam int MSGST_FILL_LSB = 8;
    localparam int MSGST_OVR_BIT = 2;
    localparam int MSGST_CRIT_BIT = 1;
    localparam int MSGST_NE_BIT = 0;
    localparam int MSGST_HWA_BIT = 8;
    localparam int MSGST_TBF_A_BIT = 4;
    localparam int MSGST_TBF_B_BIT = 5;
    localparam int MSGST_FNF_A_BIT = 2;
    localparam int MSGST_FNF_B_BIT = 3;
    localparam int MSGST_SNU_A_BIT = 0;
    localparam int MSGST_SNU_B_BIT = 1;

    // ----------------------------------------
    // reset values and limits
    // ----------------------------------------
    localparam logic [31:0] MSGST_HSTAT_RST = 32'h00000080;
    localparam logic [31:0] MSGST_LDTS_RST = 32'h00000000;
    localparam logic [15:0] MSGST_FSR_RST = 16'h0000;
    localparam logic [15:0] MSGST_HDF_RST = 16'h0000;
    localparam logic [7:0] MSGST_FILL_MAX = 8'h80;

endpackage
`default_nettype wire

/* File: msgst_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module msgst_regs (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // controller state
    input wire logic in_config_i,
    input wire logic leave_config_i,
    input wire logic enter_state_b_i,
    // ram clearing
    input wire logic cmd_a_cmd_i,
    input wire logic ram_clear_done_i,
    output logic ram_clear_busy_o,
    // buffer events
    input wire logic buf_updated_i,
    input wire logic [msgst_pkg::MSGST_BUF_W-1:0] buf_updated_num_i,
    input wire logic buf_sent_i,
    input wire logic [msgst_pkg::MSGST_BUF_W-1:0] buf_sent_num_i,
    // parity events
    input wire logic [msgst_pkg::MSGST_PAR_N-1:0] parity_err_i,
    input wire logic faulty_buf_i,
    input wire logic [msgst_pkg::MSGST_BUF_W-1:0] faulty_buf_num_i,
    // dynamic segment
    input wire logic dyn_tx_a_i,
    input wire logic dyn_tx_b_i,
    input wire logic [msgst_pkg::MSGST_SLOT_W-1:0] slot_counter_a_i,
    input wire logic [msgst_pkg::MSGST_SLOT_W-1:0] slot_counter_b_i,
    input wire logic dyn_seg_end_i,
    // receive fifo
    input wire logic fifo_store_i,
    input wire logic fifo_read_i,
    input wire logic [msgst_pkg::MSGST_FILL_W-1:0] critical_level_setting_i,
    output logic [msgst_pkg::MSGST_FILL_W-1:0] fifo_fill_level_o,
    output logic fifo_overwrite_o,
    // constraint events
    input wire logic header_write_try_i,
    output logic header_write_block_o,
    input wire logic transient_fail_a_i,
    input wire logic transient_fail_b_i,
    input wire logic find_unfinished_a_i,
    input wire logic find_unfinished_b_i,
    input wire logic status_not_updated_a_i,
    input wire logic status_not_updated_b_i,
    // interrupt flag set pulses
    output logic parity_irq_flag_o,
    output logic handler_irq_flag_o,
    output logic fifo_overrun_irq_o,
    output logic fifo_critical_irq_o,
    output logic fifo_not_empty_irq_o
);
    import msgst_pkg::*;

    // ----------------------------------------
    // address decode
    // ----------------------------------------

    // registers sit at four times their index
    function automatic logic reg_hit(input logic [31:0] adr, input logic [31:0] idx);
        reg_hit = (adr[13:2] == idx[11:0]);
    endfunction

    logic ack_q;
    logic [31:0] dat_q;
    logic req_w;
    logic wr_w;
    logic hs_hit_w;
    logic ldt_hit_w;
    logic fsr_hit_w;
    logic hdf_hit_w;
    logic [31:0] lane_w;
    logic [31:0] clr_w;

    assign req_w = wb_cyc_i & wb_stb_i;
    // a write takes effect on the edge that sees ack high
    assign wr_w = req_w & wb_we_i & ack_q;
    assign hs_hit_w = reg_hit(wb_adr_i, MSGST_HSTAT_IDX);
    assign ldt_hit_w = reg_hit(wb_adr_i, MSGST_LDTS_IDX);
    assign fsr_hit_w = reg_hit(wb_adr_i, MSGST_FSR_IDX);
    assign hdf_hit_w = reg_hit(wb_adr_i, MSGST_HDF_IDX);
    assign lane_w = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                     {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign clr_w = wb_dat_i & lane_w;

    // ----------------------------------------
    // init and write-one-to-clear masks
    // ----------------------------------------
    logic init_w;
    logic [MSGST_PAR_N-1:0] par_clr_w;
    logic det_clr_w;
    logic mult_clr_w;
    logic [MSGST_HDF_W-1:0] hdf_clr_w;

    assign init_w = leave_config_i | enter_state_b_i;
    // only the flag bits are clearable; number fields ignore writes
    assign par_clr_w = (wr_w & hs_hit_w) ?
        clr_w[MSGST_PAR_LSB +: MSGST_PAR_N] : '0;
    assign det_clr_w = wr_w & hs_hit_w & clr_w[MSGST_DET_BIT];
    assign mult_clr_w = wr_w & hs_hit_w & clr_w[MSGST_MULT_BIT];
    assign hdf_clr_w = (wr_w & hdf_hit_w) ?
        clr_w[MSGST_HDF_W-1:0] : '0;

    // ----------------------------------------
    // handler status
    // ----------------------------------------
    logic busy_q;
    logic [MSGST_BUF_W-1:0] upd_q;
    logic [MSGST_BUF_W-1:0] sent_q;
    logic [MSGST_BUF_W-1:0] faulty_q;
    logic det_q;
    logic mult_q;
    logic [MSGST_PAR_N-1:0] par_q;
    logic [MSGST_PAR_N-1:0] par_d;
    logic det_d;
    logic mult_d;
    logic par_irq_q;

    // sets win over a clear in the same cycle
    assign par_d = (par_q & ~par_clr_w) | parity_err_i;
    assign det_d = (det_q & ~det_clr_w) | faulty_buf_i;
    // a second fault while detected is still set counts as multiple
    assign mult_d = (mult_q & ~mult_clr_w) | (faulty_buf_i & det_q);

    // clearing busy runs until the ram engine reports done
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_q <= MSGST_HSTAT_RST[MSGST_BUSY_BIT];
        end else if (cmd_a_cmd_i) begin
            busy_q <= 1'b1;
        end else if (ram_clear_done_i) begin
            busy_q <= 1'b0;
        end
    end

    // last updated and last sent buffer numbers
    always_ff @(posedge clk_i) begin
        if (rst_i || cmd_a_cmd_i || init_w) begin
            upd_q <= '0;
            sent_q <= '0;
        end else begin
            if (buf_updated_i) begin
                upd_q <= buf_updated_num_i;
            end
            if (buf_sent_i) begin
                sent_q <= buf_sent_num_i;
            end
        end
    end

    // parity and faulty buffer tracking
    always_ff @(posedge clk_i) begin
        if (rst_i || cmd_a_cmd_i) begin
            par_q <= '0;
            det_q <= 1'b0;
            mult_q <= 1'b0;
            faulty_q <= '0;
        end else begin
            par_q <= par_d;
            det_q <= det_d;
            mult_q <= mult_d;
            // number is frozen while detected stays set
            if ((faulty_buf_i || (|parity_err_i)) && !det_q) begin
                faulty_q <= faulty_buf_num_i;
            end
        end
    end

    // pulse when any parity flag goes from zero to one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            par_irq_q <= 1'b0;
        end else begin
            par_irq_q <= |(par_d & ~par_q);
        end
    end

    // ----------------------------------------
    // last dynamic transmit slot, one per channel
    // ----------------------------------------
    logic [1:0] dyn_tx_w;
    logic [MSGST_SLOT_W-1:0] slot_w [2];
    logic [MSGST_SLOT_W-1:0] shadow_q [2];
    logic [1:0] seen_q;
    logic [MSGST_SLOT_W-1:0] ldt_q [2];

    assign dyn_tx_w = {dyn_tx_b_i, dyn_tx_a_i};
    assign slot_w[0] = slot_counter_a_i;
    assign slot_w[1] = slot_counter_b_i;

    // shadow holds the slot until the segment ends, so software never
    // sees a half-finished segment
    for (genvar ch = 0; ch < 2; ch++) begin : g_ldt
        always_ff @(posedge clk_i) begin
            if (rst_i || init_w) begin
                shadow_q[ch] <= '0;
                seen_q[ch] <= 1'b0;
                ldt_q[ch] <= '0;
            end else if (dyn_seg_end_i) begin
                seen_q[ch] <= 1'b0;
                if (dyn_tx_w[ch]) begin
                    ldt_q[ch] <= slot_w[ch];
                end else if (seen_q[ch]) begin
                    ldt_q[ch] <= shadow_q[ch];
                end else begin
                    ldt_q[ch] <= '0;
                end
            end else if (dyn_tx_w[ch]) begin
                shadow_q[ch] <= slot_w[ch];
                seen_q[ch] <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // receive fifo status
    // ----------------------------------------
    logic [MSGST_FILL_W-1:0] fill_q;
    logic [MSGST_FILL_W-1:0] fill_d;
    logic full_w;
    logic overrun_w;
    logic ovr_q;
    logic ovr_d;
    logic crit_q;
    logic crit_d;
    logic ne_q;
    logic ne_d;
    logic [2:0] fifo_irq_q;

    assign full_w = (fill_q == MSGST_FILL_MAX);
    // a store into a full fifo replaces the oldest entry
    assign overrun_w = fifo_store_i & full_w & ~fifo_read_i;
    assign fifo_overwrite_o = overrun_w;

    // fill level never passes 128
    always_comb begin
        fill_d = fill_q;
        if (fifo_store_i && !fifo_read_i && !full_w) begin
            fill_d = fill_q + 8'h01;
        end else if (fifo_read_i && !fifo_store_i && fill_q != '0) begin
            fill_d = fill_q - 8'h01;
        end
    end

    // overrun clears on the next read unless a new one arrives
    assign ovr_d = overrun_w | (ovr_q & ~fifo_read_i);
    // a setting above 128 can never be reached
    assign crit_d = (critical_level_setting_i <= MSGST_FILL_MAX) &&
                    (fill_d >= critical_level_setting_i);
    assign ne_d = fifo_store_i | (ne_q & (fill_d != '0));

    always_ff @(posedge clk_i) begin
        if (rst_i || init_w) begin
            fill_q <= '0;
            ovr_q <= 1'b0;
            crit_q <= 1'b0;
            ne_q <= 1'b0;
        end else begin
            fill_q <= fill_d;
            ovr_q <= ovr_d;
            crit_q <= crit_d;
            ne_q <= ne_d;
        end
    end

    // interrupt flag pulses: overrun event, critical rise, store
    always_ff @(posedge clk_i) begin
        if (rst_i || init_w) begin
            fifo_irq_q <= '0;
        end else begin
            fifo_irq_q[0] <= overrun_w;
            fifo_irq_q[1] <= crit_d & ~crit_q;
            fifo_irq_q[2] <= fifo_store_i;
        end
    end

    // ----------------------------------------
    // handler constraint flags
    // ----------------------------------------
    logic hwa_w;
    logic [MSGST_HDF_W-1:0] hdf_set_w;
    logic [MSGST_HDF_W-1:0] hdf_q;
    logic [MSGST_HDF_W-1:0] hdf_d;
    logic hdf_irq_q;

    // outside configuration the errant write is blocked
    assign hwa_w = header_write_try_i & ~in_config_i;
    assign header_write_block_o = hwa_w;

    always_comb begin
        hdf_set_w = '0;
        hdf_set_w[MSGST_HWA_BIT] = hwa_w;
        hdf_set_w[MSGST_TBF_A_BIT] = transient_fail_a_i;
        hdf_set_w[MSGST_TBF_B_BIT] = transient_fail_b_i;
        hdf_set_w[MSGST_FNF_A_BIT] = find_unfinished_a_i;
        hdf_set_w[MSGST_FNF_B_BIT] = find_unfinished_b_i;
        hdf_set_w[MSGST_SNU_A_BIT] = status_not_updated_a_i;
        hdf_set_w[MSGST_SNU_B_BIT] = status_not_updated_b_i;
    end

    // set beats clear; unused positions are never set
    assign hdf_d = (hdf_q & ~hdf_clr_w) | hdf_set_w;

    always_ff @(posedge clk_i) begin
        if (rst_i || init_w) begin
            hdf_q <= MSGST_HDF_RST[MSGST_HDF_W-1:0];
            hdf_irq_q <= 1'b0;
        end else begin
            hdf_q <= hdf_d;
            hdf_irq_q <= |(hdf_d & ~hdf_q);
        end
    end

    // ----------------------------------------
    // read words
    // ----------------------------------------
    logic [31:0] hs_word_w;
    logic [31:0] ldt_word_w;
    logic [31:0] fsr_word_w;
    logic [31:0] hdf_word_w;
    logic [31:0] rd_w;

    // everything not placed below reads zero
    always_comb begin
        hs_word_w = '0;
        hs_word_w[MSGST_UPD_LSB +: MSGST_BUF_W] = upd_q;
        hs_word_w[MSGST_SENT_LSB +: MSGST_BUF_W] = sent_q;
        hs_word_w[MSGST_FAULTY_LSB +: MSGST_BUF_W] = faulty_q;
        hs_word_w[MSGST_BUSY_BIT] = busy_q;
        hs_word_w[MSGST_MULT_BIT] = mult_q;
        hs_word_w[MSGST_DET_BIT] = det_q;
        hs_word_w[MSGST_PAR_LSB +: MSGST_PAR_N] = par_q;
        ldt_word_w = '0;
        ldt_word_w[MSGST_LDT_A_LSB +: MSGST_SLOT_W] = ldt_q[0];
        ldt_word_w[MSGST_LDT_B_LSB +: MSGST_SLOT_W] = ldt_q[1];
        fsr_word_w = '0;
        fsr_word_w[MSGST_FILL_LSB +: MSGST_FILL_W] = fill_q;
        fsr_word_w[MSGST_OVR_BIT] = ovr_q;
        fsr_word_w[MSGST_CRIT_BIT] = crit_q;
        fsr_word_w[MSGST_NE_BIT] = ne_q;
        hdf_word_w = '0;
        hdf_word_w[MSGST_HDF_W-1:0] = hdf_q;
    end

    // unmapped addresses read zero and are still acknowledged
    assign rd_w = hs_hit_w ? hs_word_w :
                  ldt_hit_w ? ldt_word_w :
                  fsr_hit_w ? fsr_word_w :
                  hdf_hit_w ? hdf_word_w : 32'h00000000;

    // ----------------------------------------
    // bus answer
    // ----------------------------------------

    // one wait cycle, then a single-cycle ack; data is sampled on the
    // request cycle so a same-cycle w1c cannot tear the read
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= req_w & ~ack_q;
            if (req_w && !ack_q) begin
                dat_q <= wb_we_i ? 32'h00000000 : rd_w;
            end
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign ram_clear_busy_o = busy_q;
    assign fifo_fill_level_o = fill_q;
    assign parity_irq_flag_o = par_irq_q;
    assign handler_irq_flag_o = hdf_irq_q;
    assign fifo_overrun_irq_o = fifo_irq_q[0];
    assign fifo_critical_irq_o = fifo_irq_q[1];
    assign fifo_not_empty_irq_o = fifo_irq_q[2];

endmodule
`default_nettype wire

/* File: msgst_regs_props.sv */
`timescale 1ns/1ps
`default_nettype none
module msgst_regs_props (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bus handshake
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    // events and results
    input wire logic in_config_i,
    input wire logic leave_config_i,
    input wire logic enter_state_b_i,
    input wire logic cmd_a_cmd_i,
    input wire logic ram_clear_busy_o,
    input wire logic header_write_try_i,
    input wire logic header_write_block_o,
    input wire logic [msgst_pkg::MSGST_PAR_N-1:0] parity_err_i,
    input wire logic parity_irq_flag_o,
    input wire logic fifo_store_i,
    input wire logic fifo_read_i,
    input wire logic [msgst_pkg::MSGST_FILL_W-1:0] fifo_fill_level_o,
    input wire logic fifo_overwrite_o,
    input wire logic fifo_not_empty_irq_o
);
    import msgst_pkg::*;
    // ----
    // one clock domain, all checks off in reset
    // ----
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic init_w;
    // init events also move the fill level, so step checks skip them
    assign init_w = leave_config_i | enter_state_b_i;
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_hdr_block: assert property (
        header_write_block_o == (header_write_try_i && !in_config_i))
        else $error("header write block mismatch");
    a_par_cause: assert property (
        parity_irq_flag_o |-> $past(parity_err_i) != 5'h00)
        else $error("parity interrupt without parity error");
    a_fill_cap: assert property (
        fifo_fill_level_o <= MSGST_FILL_MAX)
        else $error("fill level above maximum");
    a_ovw_full: assert property (
        fifo_overwrite_o |-> fifo_store_i && fifo_fill_level_o == 8'h80)
        else $error("overwrite while not full");
    a_fill_inc: assert property (
        fifo_store_i && !fifo_read_i && !init_w && fifo_fill_level_o != 8'h80
        |=> fifo_fill_level_o == $past(fifo_fill_level_o) + 8'h01)
        else $error("fill level did not count up");
    a_fill_dec: assert property (
        fifo_read_i && !fifo_store_i && !init_w && fifo_fill_level_o != 8'h00
        |=> fifo_fill_level_o == $past(fifo_fill_level_o) - 8'h01)
        else $error("fill level did not count down");
    a_busy_set: assert property (cmd_a_cmd_i |=> ram_clear_busy_o)
        else $error("clear busy not set by command");
    a_ne_cause: assert property (
        fifo_not_empty_irq_o |-> $past(fifo_store_i))
        else $error("not empty interrupt without store");
    c_overwrite: cover property (fifo_overwrite_o);
    c_parity: cover property (parity_irq_flag_o);
    c_block: cover property (header_write_block_o);
endmodule
`default_nettype wire

/* File: msgst_regs_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) chk(nm, 32'(e), 32'(g))
module msgst_regs_tb;
    import msgst_pkg::*;
    // ----
    // signals
    // ----
    logic clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
    logic in_config_i = 1'h0;
    logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0;
    logic [3:0] wb_sel_i = 4'hf;
    logic [6:0] buf_updated_num_i = 7'h5a, buf_sent_num_i = 7'h7f, faulty_buf_num_i = 7'h11;
    logic [10:0] slot_counter_a_i = 11'h7ff, slot_counter_b_i = 11'h123;
    logic [7:0] critical_level_setting_i = 8'h80;
    logic [23:0] ev = 24'h0;
    wire logic fifo_read_i, fifo_store_i, dyn_seg_end_i, dyn_tx_b_i, dyn_tx_a_i, faulty_buf_i;
    wire logic buf_sent_i, buf_updated_i, ram_clear_done_i, cmd_a_cmd_i, enter_state_b_i;
    wire logic leave_config_i, header_write_try_i, transient_fail_b_i, transient_fail_a_i;
    wire logic find_unfinished_b_i, find_unfinished_a_i, status_not_updated_b_i;
    wire logic status_not_updated_a_i;
    wire logic [4:0] parity_err_i;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, ram_clear_busy_o, fifo_overwrite_o, header_write_block_o, parity_irq_flag_o;
    logic handler_irq_flag_o, fifo_overrun_irq_o, fifo_critical_irq_o, fifo_not_empty_irq_o;
    logic [7:0] fifo_fill_level_o;
    logic [4:0] irq;
    logic [1:0] comb;
    int n_fail = 0, checks = 0;
    localparam logic [31:0] A_HS = {18'h0, MSGST_HSTAT_IDX[11:0], 2'h0};
    localparam logic [31:0] A_LD = {18'h0, MSGST_LDTS_IDX[11:0], 2'h0};
    localparam logic [31:0] A_FS = {18'h0, MSGST_FSR_IDX[11:0], 2'h0};
    localparam logic [31:0] A_HF = {18'h0, MSGST_HDF_IDX[11:0], 2'h0};
    // one event bit per pulse input, so one task drives them all
    assign {fifo_read_i, fifo_store_i, dyn_seg_end_i, dyn_tx_b_i, dyn_tx_a_i, faulty_buf_i,
        buf_sent_i, buf_updated_i, ram_clear_done_i, cmd_a_cmd_i, enter_state_b_i,
        leave_config_i, header_write_try_i, transient_fail_b_i, transient_fail_a_i,
        find_unfinished_b_i, find_unfinished_a_i, status_not_updated_b_i,
        status_not_updated_a_i, parity_err_i} = ev;
    msgst_regs msgst_regs_inst (.*);
    always #2 clk_i = ~clk_i;
    // ----
    // tasks
    // ----
    task automatic final_report();
        if (n_fail == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // classic cycle: hold until ack is sampled, bounded wait
    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 16);
        if (n >= 16) begin
            n_fail++;
            final_report();
        end else begin
            q = wb_dat_o;
            wb_cyc_i <= 1'h0;
            wb_stb_i <= 1'h0;
            wb_we_i <= 1'h0;
        end
    endtask
    task automatic rd(input string nm, input logic [31:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'h0, a, 32'h0, q);
        `CHK(nm, e, q);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'h1, a, d, q);
    endtask
    // one-cycle event; samples combinational results, then the irq pulses
    task automatic pulse(input logic [23:0] m);
        @(posedge clk_i) ev <= m;
        @(negedge clk_i) comb = {fifo_overwrite_o, header_write_block_o};
        @(posedge clk_i) ev <= 24'h0;
        @(negedge clk_i) irq = {fifo_not_empty_irq_o, fifo_critical_irq_o, fifo_overrun_irq_o,
            handler_irq_flag_o, parity_irq_flag_o};
    endtask
    // ----
    // scenarios
    // ----
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'h0;
        rd("hs reset", A_HS, 32'h80);
        `CHK("busy pin", 1'h1, ram_clear_busy_o);
        rd("ld reset", A_LD, 32'h0);
        rd("fs reset", A_FS, 32'h0);
        rd("hf reset", A_HF, 32'h0);
        rd("unmapped", 32'h00000c44, 32'h0);
        wr(A_HS, 32'hffffffff);
        rd("hs busy ro", A_HS, 32'h80);
        pulse(24'h1 << 15);
        rd("hs done", A_HS, 32'h0);
        `CHK("busy pin done", 1'h0, ram_clear_busy_o);
        pulse((24'h1 << 16) | (24'h1 << 17));
        rd("hs bufs", A_HS, 32'h5a7f0000);
        pulse(24'h1 << 12);
        rd("hs leave", A_HS, 32'h0);
        pulse(24'h1 << 16);
        pulse(24'h1 << 13);
        rd("hs state_b", A_HS, 32'h0);
        for (int i = 0; i < 5; i++) begin
            pulse(24'h1 << i);
            `CHK("parity irq", 1'h1, irq[0]);
        end
        pulse(24'h1 << 18);
        @(posedge clk_i) faulty_buf_num_i <= 7'h22;
        pulse(24'h1 << 18);
        pulse(24'h1);
        `CHK("parity irq again", 1'h0, irq[0]);
        rd("hs faulty", A_HS, 32'h0000117f);
        wr(A_HS, 32'h00000021);
        rd("hs w1c", A_HS, 32'h0000115e);
        pulse(24'h1 << 14);
        rd("hs clear", A_HS, 32'h80);
        `CHK("busy pin clear", 1'h1, ram_clear_busy_o);
        pulse(24'h1 << 15);
        pulse((24'h1 << 19) | (24'h1 << 20));
        pulse(24'h1 << 21);
        rd("ld slots", A_LD, 32'h012307ff);
        wr(A_LD, 32'hffffffff);
        rd("ld ro", A_LD, 32'h012307ff);
        pulse(24'h1 << 21);
        rd("ld none", A_LD, 32'h0);
        @(posedge clk_i) critical_level_setting_i <= 8'h03;
        pulse(24'h1 << 22);
        `CHK("ne irq", 1'h1, irq[4]);
        repeat (2) pulse(24'h1 << 22);
        `CHK("crit irq", 1'h1, irq[3]);
        rd("fs three", A_FS, 32'h0303);
        repeat (125) pulse(24'h1 << 22);
        rd("fs full", A_FS, 32'h8003);
        `CHK("fill pin", 8'h80, fifo_fill_level_o);
        pulse(24'h1 << 22);
        `CHK("overwrite", 1'h1, comb[1]);
        `CHK("ovr irq", 1'h1, irq[2]);
        rd("fs overrun", A_FS, 32'h8007);
        pulse(24'h1 << 23);
        rd("fs read", A_FS, 32'h7f03);
        repeat (127) pulse(24'h1 << 23);
        rd("fs empty", A_FS, 32'h0);
        @(posedge clk_i) critical_level_setting_i <= 8'h81;
        repeat (128) pulse(24'h1 << 22);
        wr(A_FS, 32'hffffffff);
        rd("fs high cl", A_FS, 32'h8001);
        pulse(24'h1 << 12);
        rd("fs init", A_FS, 32'h0);
        for (int i = 0; i < 7; i++) begin
            pulse(24'h1 << (5 + i));
            `CHK("handler irq", 1'h1, irq[1]);
        end
        `CHK("hdr block", 1'h1, comb[0]);
        rd("hf all", A_HF, 32'h013f);
        pulse(24'h1 << 5);
        `CHK("handler irq again", 1'h0, irq[1]);
        // only the byte lane of the header flag is enabled here
        @(posedge clk_i) wb_sel_i <= 4'h2;
        wr(A_HF, 32'h00000101);
        rd("hf lane", A_HF, 32'h003f);
        @(posedge clk_i) wb_sel_i <= 4'hf;
        wr(A_HF, 32'h00000001);
        rd("hf w1c", A_HF, 32'h003e);
        @(posedge clk_i) in_config_i <= 1'h1;
        pulse(24'h1 << 11);
        `CHK("hdr in config", 1'h0, comb[0]);
        rd("hf in config", A_HF, 32'h003e);
        pulse(24'h1 << 13);
        rd("hf init", A_HF, 32'h0);
        final_report();
    end
endmodule
bind msgst_regs msgst_regs_props msgst_regs_props_inst (.*);
`default_nettype wire
